// ---- hw/flyback_mode_fault_sequencer.sv ----
// supply states, start-up probing, fault lockout and minimum frequency control
`timescale 1ns/1ps
module flyback_mode_fault_sequencer
	import flyback_seq_pkg::*;
#(
	parameter logic [TIMER_W-1:0] SOFT_SHORT_CYCLES = TIMER_W'(SOFT_SHORT_CYC),
	parameter logic [TIMER_W-1:0] RAISED_HOLD_CYCLES = TIMER_W'(RAISED_HOLD_CYC)
) (
	input wire logic clk, // 100 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire logic ce, // clock enable, freezes state when low
	input wire analog_in_s ain, // comparator decisions and cycle pulses
	output logic pwm_enable, // gate drive allowed
	output logic peak_limit_lower, // force lowest peak current
	output bias_e bias_mode, // requested bias current level
	output logic cc_mode, // output current limiting active
	output logic soft_short_latched, // soft-short latch
	output logic soft_short_fault, // one-cycle pulse at declaration
	output logic [1:0] lockout_count, // lockout cycles passed while latched
	output logic raised_min_active, // raised minimum frequency in force
	output logic [16:0] min_period_cycles // longest allowed switching period
);

	function automatic logic switching(input seq_state_e st);
		switching = (st == ST_PROBE) || (st == ST_RUN);
	endfunction

	seq_s s_reg;
	seq_s s_next;
	logic ss_armed;
	logic ss_expire;
	logic go_fault;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next = s_reg;
		s_next.fault_pulse = 1'b0;
		ss_armed = 1'b0;
		ss_expire = 1'b0;
		go_fault = 1'b0;
		case (s_reg.st)
			ST_START: begin
				if (ain.supply_above_on) begin
					s_next.probe_cnt = 2'h0;
					if (!s_reg.latch) begin
						s_next.st = ST_PROBE;
					end else if (s_reg.lock_cnt == LOCKOUT_CYCLES) begin
						s_next.latch = 1'b0;
						s_next.lock_cnt = 2'h0;
						s_next.st = ST_PROBE;
					end else begin
						s_next.lock_cnt = s_reg.lock_cnt + 2'h1;
						s_next.st = ST_FAULT;
					end
				end
			end
			ST_PROBE: begin
				if (ain.cycle_start && s_reg.probe_cnt != PROBE_CYCLES) begin
					s_next.probe_cnt = s_reg.probe_cnt + 2'h1;
				end
				if (ain.demag_end && s_reg.probe_cnt == PROBE_CYCLES) begin
					if (ain.input_run_ok && !ain.fault_detect) begin
						s_next.st = ST_RUN;
					end else begin
						go_fault = 1'b1;
					end
				end
			end
			ST_RUN: begin
				// current limiting whenever output sits below regulation
				s_next.cc = ain.sense_below_reg;
				ss_armed = ain.sense_below_reg && ain.sense_below_soft_short;
				if (!ss_armed) begin
					s_next.ss_cnt = '0;
				end else if (s_reg.ss_cnt == SOFT_SHORT_CYCLES - 26'h1) begin
					ss_expire = 1'b1;
				end else begin
					s_next.ss_cnt = s_reg.ss_cnt + 26'h1;
				end
			end
			ST_THERM: begin
				if (!ain.thermistor_below_trip) begin
					s_next.st = ST_RUN;
				end
			end
			ST_FAULT: begin
				if (!ain.supply_above_off) begin
					s_next.st = ST_START;
				end
			end
			default: begin
				s_next = SEQ_RESET;
			end
		endcase

		// priorities among stop events, supply collapse above all
		if (switching(s_reg.st) || s_reg.st == ST_THERM) begin
			if (ain.fault_detect) begin
				go_fault = 1'b1;
			end
			if (ss_expire) begin
				s_next.latch = 1'b1;
				s_next.lock_cnt = 2'h0;
				s_next.fault_pulse = 1'b1;
				go_fault = 1'b1;
			end
			if (go_fault) begin
				s_next.st = ST_FAULT;
			end else if (switching(s_reg.st) && ain.thermistor_below_trip) begin
				s_next.st = ST_THERM;
			end
			if (!ain.supply_above_off) begin
				s_next.st = ST_START;
			end
		end
		if (go_fault && s_reg.st == ST_PROBE && !ain.supply_above_off) begin
			s_next.st = ST_START;
		end

		if (s_next.st != ST_RUN) begin
			s_next.cc = 1'b0;
			s_next.ss_cnt = '0;
		end

		// bias request follows the state being entered
		case (s_next.st)
			ST_START: s_next.bias = BIAS_START;
			ST_PROBE: s_next.bias = BIAS_RUN;
			ST_RUN: begin
				if (ain.peak_at_upper) begin
					s_next.bias = BIAS_RUN;
				end else if (ain.demag_end) begin
					s_next.bias = BIAS_WAIT;
				end else if (ain.cycle_start || s_reg.st != ST_RUN) begin
					s_next.bias = BIAS_RUN;
				end else begin
					s_next.bias = s_reg.bias;
				end
			end
			default: s_next.bias = BIAS_FAULT;
		endcase
		s_next.pwm_en = switching(s_next.st);
		s_next.peak_low = (s_next.st == ST_PROBE);

		// dynamic minimum switching frequency
		if (s_next.st != ST_RUN) begin
			s_next.hold = 1'b0;
			s_next.reg_cnt = '0;
		end else if (ain.load_mid_high || ain.loop_freq_above_lim) begin
			s_next.hold = 1'b1;
			s_next.reg_cnt = '0;
		end else if (s_reg.hold) begin
			if (ain.sense_over_reg_10pct) begin
				s_next.hold = 1'b0;
				s_next.reg_cnt = '0;
			end else if (!ain.sense_above_reg) begin
				s_next.reg_cnt = '0;
			end else if (s_reg.reg_cnt == RAISED_HOLD_CYCLES - 26'h1) begin
				s_next.hold = 1'b0;
				s_next.reg_cnt = '0;
			end else begin
				s_next.reg_cnt = s_reg.reg_cnt + 26'h1;
			end
		end
		s_next.min_period = s_next.hold ? RAISED_MIN_PERIOD : ABS_MIN_PERIOD;
	end

	// latch and count are cleared by srst and at lockout release, never by supply collapse
	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= SEQ_RESET;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign pwm_enable = s_reg.pwm_en;
	assign peak_limit_lower = s_reg.peak_low;
	assign bias_mode = s_reg.bias;
	assign cc_mode = s_reg.cc;
	assign soft_short_latched = s_reg.latch;
	assign soft_short_fault = s_reg.fault_pulse;
	assign lockout_count = s_reg.lock_cnt;
	assign raised_min_active = s_reg.hold;
	assign min_period_cycles = s_reg.min_period;

	////////////////////////////////////////////////////////////////////////////
	property p_ss_declare;
		@(posedge clk) disable iff (srst)
		$rose(s_reg.latch) |-> $past(s_reg.ss_cnt) == SOFT_SHORT_CYCLES - 26'h1
			&& $past(s_reg.st) == ST_RUN && s_reg.st == ST_FAULT && soft_short_fault;
	endproperty
	a_ss_declare: assert property (p_ss_declare)
		else $error("soft-short latch set without full timer run");

	property p_ss_armed;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_RUN && !(ain.sense_below_reg && ain.sense_below_soft_short))
			|=> s_reg.ss_cnt == 26'h0;
	endproperty
	a_ss_armed: assert property (p_ss_armed)
		else $error("soft-short timer ran while not armed");

	property p_ss_restart;
		@(posedge clk) disable iff (srst)
		(s_reg.ss_cnt != 26'h0) |-> $past(s_reg.st) == ST_RUN && s_reg.st == ST_RUN
			&& $past(ain.sense_below_soft_short) && $past(ain.sense_below_reg);
	endproperty
	a_ss_restart: assert property (p_ss_restart)
		else $error("soft-short timer kept value after condition ended");

	property p_lockout_hold;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_START && ain.supply_above_on && s_reg.latch
			&& s_reg.lock_cnt != LOCKOUT_CYCLES)
			|=> !pwm_enable && s_reg.st == ST_FAULT && soft_short_latched
			&& lockout_count == $past(s_reg.lock_cnt) + 2'h1;
	endproperty
	a_lockout_hold: assert property (p_lockout_hold)
		else $error("latched power-up did not stay off and count");

	property p_lockout_release;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_START && ain.supply_above_on && s_reg.latch
			&& s_reg.lock_cnt == LOCKOUT_CYCLES)
			|=> !soft_short_latched && pwm_enable && peak_limit_lower;
	endproperty
	a_lockout_release: assert property (p_lockout_release)
		else $error("fourth power-up did not release the latch");

	property p_latch_kept;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.latch && s_reg.st == ST_FAULT && !ain.supply_above_off)
			|=> s_reg.latch && s_reg.st == ST_START && bias_mode == BIAS_START;
	endproperty
	a_latch_kept: assert property (p_latch_kept)
		else $error("latch lost at supply turn-off");

	property p_wait_start;
		@(posedge clk) disable iff (srst)
		(s_reg.st == ST_START) |-> !pwm_enable && bias_mode == BIAS_START;
	endproperty
	a_wait_start: assert property (p_wait_start)
		else $error("switching below turn-on");

	property p_probe_low;
		@(posedge clk) disable iff (srst)
		(s_reg.st == ST_PROBE) |-> peak_limit_lower && pwm_enable;
	endproperty
	a_probe_low: assert property (p_probe_low)
		else $error("probe cycle without lowest peak current");

	property p_run_entry;
		@(posedge clk) disable iff (srst)
		(s_reg.st == ST_RUN && $past(s_reg.st) == ST_PROBE)
			|-> $past(ain.input_run_ok) && !$past(ain.fault_detect)
			&& $past(s_reg.probe_cnt) == PROBE_CYCLES;
	endproperty
	a_run_entry: assert property (p_run_entry)
		else $error("normal run entered without confirmation");

	property p_supply_drop;
		@(posedge clk) disable iff (srst)
		(ce && switching(s_reg.st) && !ain.supply_above_off)
			|=> s_reg.st == ST_START && !pwm_enable ##1 !pwm_enable || ain.supply_above_on;
	endproperty
	a_supply_drop: assert property (p_supply_drop)
		else $error("switching continued below turn-off");

	property p_fault_stop;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_RUN && ain.fault_detect && ain.supply_above_off)
			|=> s_reg.st == ST_FAULT && !pwm_enable && bias_mode == BIAS_FAULT;
	endproperty
	a_fault_stop: assert property (p_fault_stop)
		else $error("fault did not stop switching");

	property p_therm;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_RUN && ain.thermistor_below_trip && ain.supply_above_off
			&& !ain.fault_detect && !ss_expire) |=> !pwm_enable && s_reg.st == ST_THERM;
	endproperty
	a_therm: assert property (p_therm)
		else $error("thermistor pull-down ignored");

	property p_upper_run;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_RUN && s_next.st == ST_RUN && ain.peak_at_upper)
			|=> bias_mode == BIAS_RUN;
	endproperty
	a_upper_run: assert property (p_upper_run)
		else $error("wait bias at upper peak current");

	property p_raised;
		@(posedge clk) disable iff (srst)
		(ce && s_reg.st == ST_RUN && s_next.st == ST_RUN
			&& (ain.load_mid_high || ain.loop_freq_above_lim))
			|=> min_period_cycles == RAISED_MIN_PERIOD && raised_min_active;
	endproperty
	a_raised: assert property (p_raised)
		else $error("raised minimum frequency not applied");

	property p_release;
		@(posedge clk) disable iff (srst)
		$fell(s_reg.hold) && s_reg.st == ST_RUN |-> $past(ain.sense_over_reg_10pct)
			|| $past(s_reg.reg_cnt) == RAISED_HOLD_CYCLES - 26'h1;
	endproperty
	a_release: assert property (p_release)
		else $error("raised minimum dropped early");

	property p_abs_min;
		@(posedge clk) disable iff (srst)
		!raised_min_active |-> min_period_cycles == ABS_MIN_PERIOD;
	endproperty
	a_abs_min: assert property (p_abs_min)
		else $error("absolute minimum frequency not allowed");
endmodule

// ---- pkg/flyback_seq_pkg.sv ----
// constants, types and state layout of the flyback mode and fault sequencer
////////////////////////////////////////////////////////////////////////////////
package flyback_seq_pkg;
	localparam longint unsigned CLK_HZ = 64'd100000000;
	localparam longint unsigned SOFT_SHORT_MS = 64'd120;
	localparam longint unsigned RAISED_HOLD_MS = 64'd500;
	localparam longint unsigned SOFT_SHORT_CYC = (SOFT_SHORT_MS * CLK_HZ) / 64'd1000;
	localparam longint unsigned RAISED_HOLD_CYC = (RAISED_HOLD_MS * CLK_HZ) / 64'd1000;
	localparam longint unsigned ABS_MIN_HZ = 64'd1000;
	localparam longint unsigned RAISED_MIN_HZ = 64'd4000;
	localparam int TIMER_W = 26;
	localparam logic [16:0] ABS_MIN_PERIOD = 17'(CLK_HZ / ABS_MIN_HZ);
	localparam logic [16:0] RAISED_MIN_PERIOD = 17'(CLK_HZ / RAISED_MIN_HZ);
	localparam logic [1:0] PROBE_CYCLES = 2'h3;
	localparam logic [1:0] LOCKOUT_CYCLES = 2'h3;

	typedef enum logic [2:0] {ST_START, ST_PROBE, ST_RUN, ST_THERM, ST_FAULT} seq_state_e;
	typedef enum logic [1:0] {BIAS_START, BIAS_RUN, BIAS_WAIT, BIAS_FAULT} bias_e;

	typedef struct packed {
		logic supply_above_on;
		logic supply_above_off;
		logic sense_below_reg;
		logic sense_below_soft_short;
		logic sense_above_reg;
		logic sense_over_reg_10pct;
		logic thermistor_below_trip;
		logic peak_at_upper;
		logic input_run_ok;
		logic fault_detect;
		logic cycle_start;
		logic demag_end;
		logic load_mid_high;
		logic loop_freq_above_lim;
	} analog_in_s;

	typedef struct packed {
		seq_state_e st;
		bias_e bias;
		logic pwm_en;
		logic peak_low;
		logic cc;
		logic latch;
		logic [1:0] lock_cnt;
		logic fault_pulse;
		logic [1:0] probe_cnt;
		logic [TIMER_W-1:0] ss_cnt;
		logic hold;
		logic [TIMER_W-1:0] reg_cnt;
		logic [16:0] min_period;
	} seq_s;

	localparam seq_s SEQ_RESET = '{
		st: ST_START, bias: BIAS_START, pwm_en: 1'b0, peak_low: 1'b0, cc: 1'b0,
		latch: 1'b0, lock_cnt: 2'h0, fault_pulse: 1'b0, probe_cnt: 2'h0,
		ss_cnt: 26'h0, hold: 1'b0, reg_cnt: 26'h0, min_period: ABS_MIN_PERIOD};
endpackage

// ---- sim/analog_front_model.sv ----
// supply and switching-cycle model standing beside the sequencer
`timescale 1ns/1ps
module analog_front_model
	import flyback_seq_pkg::*;
#(
	parameter int ON_LVL = 40,
	parameter int OFF_LVL = 10,
	parameter int PERIOD = 8
) (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic drain, // forces supply collapse
	input wire logic pwm_enable, // gate drive allowed
	input wire bias_e bias_mode, // bias drawn by the sequencer
	output logic supply_above_on, // supply over turn-on
	output logic supply_above_off, // supply over turn-off
	output logic cycle_start, // switching cycle begins
	output logic demag_end // demagnetisation finished
);
	int vdd;
	int ph;
	always @(posedge clk) begin
		if (srst) begin
			vdd <= 0;
			ph <= 0;
		end else begin
			if (drain || bias_mode == BIAS_FAULT)
				vdd <= (vdd > 0) ? vdd - 1 : 0;
			else if (bias_mode == BIAS_START && vdd < 50)
				vdd <= vdd + 1;
			ph <= pwm_enable ? (ph + 1) % PERIOD : 0;
		end
	end
	// aux winding holds the supply while running
	assign supply_above_on = vdd > ON_LVL;
	assign supply_above_off = vdd > OFF_LVL;
	assign cycle_start = pwm_enable && ph == 1;
	assign demag_end = pwm_enable && ph == PERIOD / 2;
endmodule

// ---- sim/tb.sv ----
// self-checking bench of the flyback mode and fault sequencer
`timescale 1ns/1ps
module tb
	import flyback_seq_pkg::*;
;
	localparam int SS_N = 20;
	localparam int HOLD_N = 30;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic drain = 1'b0;
	logic ce = 1'b1;
	analog_in_s drv = '0;
	analog_in_s ain;
	logic sup_on, sup_off, cyc, dmg;
	logic pwm_enable, peak_limit_lower, cc_mode, soft_short_latched, soft_short_fault;
	logic raised_min_active;
	bias_e bias_mode;
	logic [1:0] lockout_count;
	logic [16:0] min_period_cycles;
	int fails = 0;
	int checked = 0;
	int seed = 32'h6dfb;
	int n;
	int hold_m = 0;
	int cnt_m = 0;
	always #5 clk = ~clk;
	always_comb begin
		ain = drv;
		ain.supply_above_on = sup_on;
		ain.supply_above_off = sup_off;
		ain.cycle_start = cyc;
		ain.demag_end = dmg;
	end
	flyback_mode_fault_sequencer #(.SOFT_SHORT_CYCLES(26'(SS_N)), .RAISED_HOLD_CYCLES(26'(HOLD_N)))
		flyback_mode_fault_sequencer_i (.clk(clk), .srst(srst), .ce(ce), .ain(ain),
		.pwm_enable(pwm_enable), .peak_limit_lower(peak_limit_lower), .bias_mode(bias_mode),
		.cc_mode(cc_mode), .soft_short_latched(soft_short_latched),
		.soft_short_fault(soft_short_fault), .lockout_count(lockout_count),
		.raised_min_active(raised_min_active), .min_period_cycles(min_period_cycles));
	analog_front_model analog_front_model_i (.clk(clk), .srst(srst), .drain(drain),
		.pwm_enable(pwm_enable), .bias_mode(bias_mode), .supply_above_on(sup_on),
		.supply_above_off(sup_off), .cycle_start(cyc), .demag_end(dmg));
	// integer model of the raised minimum frequency hold, run means switching past probing
	always @(posedge clk) begin
		if (srst || (ce && !(pwm_enable && !peak_limit_lower))) begin
			hold_m = 0;
			cnt_m = 0;
		end else if (ce) begin
			if (drv.load_mid_high || drv.loop_freq_above_lim) begin
				hold_m = 1;
				cnt_m = 0;
			end else if (hold_m != 0) begin
				if (drv.sense_over_reg_10pct) begin
					hold_m = 0;
					cnt_m = 0;
				end else if (!drv.sense_above_reg) begin
					cnt_m = 0;
				end else if (cnt_m == HOLD_N - 1) begin
					hold_m = 0;
					cnt_m = 0;
				end else begin
					cnt_m++;
				end
			end
		end
	end
	always @(negedge clk) begin
		if (!srst && pwm_enable && !peak_limit_lower) begin
			chk(raised_min_active, hold_m);
			chk(min_period_cycles, (hold_m != 0) ? RAISED_MIN_PERIOD : ABS_MIN_PERIOD);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask
	function automatic logic [31:0] cur(input int w);
		case (w)
			0: return 32'(pwm_enable);
			1: return 32'(bias_mode);
			2: return 32'(lockout_count);
			3: return 32'(soft_short_latched);
			4: return 32'(dmg);
			5: return 32'(cyc);
			default: return 32'(peak_limit_lower);
		endcase
	endfunction
	// bounded wait for an output or partner line to reach a value
	task automatic wait_on(input int w, input logic [31:0] v);
		int k;
		k = 0;
		while (cur(w) !== v && k < 1000) begin
			step(1);
			k++;
		end
		chk(32'(k < 1000), 32'h1);
	endtask
	task automatic power_up();
		step(10);
		chk(pwm_enable, 1'b0);
		wait_on(0, 1);
		chk(peak_limit_lower, 1'b1);
		n = 0;
		for (int k = 0; k < 200 && peak_limit_lower; k++) begin
			if (cyc)
				n++;
			step(1);
		end
		chk(n, 3);
		chk(pwm_enable, 1'b1);
	endtask
	task automatic end_of_test();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		drv.input_run_ok = 1'b1;
		step(5);
		srst = 1'b0;
		chk(bias_mode, BIAS_START);
		chk(min_period_cycles, 17'h186A0);
		power_up();
		wait_on(4, 1);
		step(1);
		chk(bias_mode, BIAS_WAIT);
		wait_on(5, 1);
		step(1);
		chk(bias_mode, BIAS_RUN);
		drv.peak_at_upper = 1'b1;
		for (int k = 0; k < 16; k++) begin
			step(1);
			chk(bias_mode, BIAS_RUN);
		end
		drv.sense_below_reg = 1'b1;
		step(2);
		chk(cc_mode, 1'b1);
		drv.sense_below_reg = 1'b0;
		drv.sense_below_soft_short = 1'b1;
		step(SS_N + 5);
		chk(soft_short_latched, 1'b0);
		drv.sense_below_reg = 1'b1;
		for (int k = 0; k < 4; k++) begin
			drv.sense_below_soft_short = 1'b0;
			step(1);
			drv.sense_below_soft_short = 1'b1;
			step(1 + ($unsigned($random(seed)) % (SS_N - 1)));
		end
		chk(soft_short_latched, 1'b0);
		drv.sense_below_soft_short = 1'b0;
		step(1);
		drv.sense_below_soft_short = 1'b1;
		step(SS_N - 1);
		chk(soft_short_latched, 1'b0);
		step(1);
		chk(soft_short_latched, 1'b1);
		chk(soft_short_fault, 1'b1);
		chk(pwm_enable, 1'b0);
		step(1);
		chk(soft_short_fault, 1'b0);
		for (int k = 1; k < 4; k++) begin
			wait_on(2, k);
			chk(pwm_enable, 1'b0);
			chk(soft_short_latched, 1'b1);
		end
		wait_on(3, 0);
		wait_on(0, 1);
		chk(lockout_count, 2'h0);
		wait_on(6, 0);
		step(SS_N - 1);
		chk(soft_short_latched, 1'b0);
		step(1);
		chk(soft_short_latched, 1'b1);
		chk(pwm_enable, 1'b0);
		srst = 1'b1;
		drv.sense_below_soft_short = 1'b0;
		drv.sense_below_reg = 1'b0;
		step(2);
		srst = 1'b0;
		power_up();
		drv.load_mid_high = 1'b1;
		step(2);
		chk(min_period_cycles, 17'h061A8);
		drv.load_mid_high = 1'b0;
		step(HOLD_N + 5);
		chk(raised_min_active, 1'b1);
		drv.sense_over_reg_10pct = 1'b1;
		step(2);
		chk(raised_min_active, 1'b0);
		chk(min_period_cycles, 17'h186A0);
		drv.sense_over_reg_10pct = 1'b0;
		drv.load_mid_high = 1'b1;
		step(1);
		drv.load_mid_high = 1'b0;
		drv.sense_above_reg = 1'b1;
		step(HOLD_N - 2);
		chk(raised_min_active, 1'b1);
		step(3);
		chk(raised_min_active, 1'b0);
		drv.loop_freq_above_lim = 1'b1;
		step(HOLD_N * 3);
		chk(min_period_cycles, 17'h061A8);
		drv.loop_freq_above_lim = 1'b0;
		drv.sense_above_reg = 1'b0;
		drv.thermistor_below_trip = 1'b1;
		ce = 1'b0;
		step(3);
		chk(pwm_enable, 1'b1);
		chk(raised_min_active, 1'b1);
		ce = 1'b1;
		step(2);
		chk(pwm_enable, 1'b0);
		chk(bias_mode, BIAS_FAULT);
		drv.thermistor_below_trip = 1'b0;
		step(2);
		chk(pwm_enable, 1'b1);
		drain = 1'b1;
		wait_on(1, BIAS_START);
		chk(pwm_enable, 1'b0);
		drain = 1'b0;
		wait_on(6, 1);
		wait_on(6, 0);
		drv.fault_detect = 1'b1;
		step(2);
		chk(bias_mode, BIAS_FAULT);
		drv.fault_detect = 1'b0;
		drv.input_run_ok = 1'b0;
		wait_on(1, BIAS_START);
		chk(pwm_enable, 1'b0);
		wait_on(0, 1);
		wait_on(1, BIAS_FAULT);
		chk(pwm_enable, 1'b0);
		drv.input_run_ok = 1'b1;
		wait_on(1, BIAS_START);
		wait_on(0, 1);
		wait_on(6, 0);
		step(2);
		chk(pwm_enable, 1'b1);
		end_of_test();
	end
endmodule
